// ### rtl/status_word_consts.svh
`ifndef STATUS_WORD_CONSTS_SVH
`define STATUS_WORD_CONSTS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SW_ADDR_STATUS      32'h0000_0000
`define SW_ADDR_ACC         32'h0000_0004
`define SW_ADDR_BITOP       32'h0000_0008
`define SW_ADDR_BANK        32'h0000_000C

// ----------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------
`define SW_BIT_CARRY        7
`define SW_BIT_NIBBLE       6
`define SW_BIT_USER0        5
`define SW_BIT_BANK_HI      4
`define SW_BIT_BANK_LO      3
`define SW_BIT_OVF          2
`define SW_BIT_USER1        1
`define SW_BIT_PARITY       0
`define SW_RESET            8'h00
`define SW_WR_MASK          8'hFE
`define SW_HW_KEEP_MASK     8'h3A
`define ACC_RESET           8'h00
`define BANK_BYTES          8'h08
`define MUL_LIMIT           16'h00FF

`endif

// ### rtl/status_word_pkg.sv
package status_word_pkg;
    typedef enum logic [2:0] {
        OP_NONE, OP_ADD, OP_ADDC, OP_SUBB, OP_MUL, OP_DIV, OP_DA
    } alu_op_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] acc;
    } flag_state_t;

    typedef struct packed {
        logic        pend;
        logic        write;
        logic [3:0]  addr;
        logic        ready;
        logic [31:0] rdata;
    } bus_state_t;
endpackage

// ### rtl/flag_compute.sv
`timescale 1ns/10ps
`include "status_word_consts.svh"

// arithmetic flag evaluation, purely combinational
module flag_compute
    import status_word_pkg::*;
(
    input  wire alu_op_t    op,
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       cin,
    output logic            upd,
    output logic            carry,
    output logic            nibble,
    output logic            ovf,
    output logic            ovf_upd,
    output logic            nibble_upd,
    output logic [7:0]      result
);
    logic [8:0]  sum9;
    logic [4:0]  lo5;
    logic [15:0] prod;

    // result and carries per operation
    always_comb begin
        sum9       = 9'h000;
        lo5        = 5'h00;
        prod       = 16'h0000;
        upd        = 1'b0;
        carry      = 1'b0;
        nibble     = 1'b0;
        ovf        = 1'b0;
        ovf_upd    = 1'b0;
        nibble_upd = 1'b0;
        result     = a;
        unique case (op)
            OP_ADD, OP_ADDC: begin
                sum9       = {1'b0, a} + {1'b0, b} + {8'h00, cin & (op == OP_ADDC)};
                lo5        = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin & (op == OP_ADDC)};
                result     = sum9[7:0];
                upd        = 1'b1;
                carry      = sum9[8];                                   // RQ1 RQ2
                nibble     = lo5[4];                                    // RQ3
                nibble_upd = 1'b1;
                ovf        = (a[7] == b[7]) && (sum9[7] != a[7]);       // RQ7
                ovf_upd    = 1'b1;
            end
            OP_SUBB: begin
                sum9       = {1'b0, a} - {1'b0, b} - {8'h00, cin};
                lo5        = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
                result     = sum9[7:0];
                upd        = 1'b1;
                carry      = sum9[8];                                   // RQ1 RQ2
                nibble     = lo5[4];                                    // RQ3
                nibble_upd = 1'b1;
                ovf        = (a[7] != b[7]) && (sum9[7] != a[7]);       // RQ7
                ovf_upd    = 1'b1;
            end
            OP_MUL: begin
                prod    = {8'h00, a} * {8'h00, b};
                result  = prod[7:0];
                upd     = 1'b1;
                carry   = 1'b0;                                         // RQ2
                ovf     = prod > `MUL_LIMIT;                             // RQ7
                ovf_upd = 1'b1;
            end
            OP_DIV: begin
                result  = (b == 8'h00) ? 8'h00 : a / b;
                upd     = 1'b1;
                carry   = 1'b0;                                         // RQ2
                ovf     = (b == 8'h00);                                 // RQ7
                ovf_upd = 1'b1;
            end
            OP_DA: begin
                // decimal adjust: only carry may be raised, never cleared
                sum9   = {1'b0, a};
                if (a[3:0] > 4'h9 || b[0])
                    sum9 = sum9 + 9'h006;
                if (sum9[8:4] > 5'h09 || cin)
                    sum9 = sum9 + 9'h060;
                result = sum9[7:0];
                upd    = 1'b1;
                carry  = sum9[8] | cin;                                 // RQ1
            end
            default: begin
                upd = 1'b0;
            end
        endcase
    end
endmodule // flag_compute

// ### rtl/cpu_status_flag_logic.sv
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`include "status_word_consts.svh"

// Overview of operation
// (RQ1) carry flag, bit 7, set on addition carry out or subtraction borrow.
// (RQ2) arithmetic with neither carry nor borrow clears the carry flag.
// (RQ3) nibble carry, bit 6, follows carry into or borrow from upper nibble.
// (RQ4) bits 5 and 1 are software flags, untouched by hardware, bit addressable.
// (RQ5) parity, bit 0, always shows odd count of ones in the accumulator.
// (RQ6) bank select bits pick one of four banks, base equals bank times eight.
// (RQ7) overflow, bit 2, on signed overflow, product above 255, divide by zero.
module cpu_status_flag_logic
    import status_word_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // core arithmetic side
    input  wire alu_op_t     alu_op,
    input  wire logic [7:0]  alu_b,
    input  wire logic        acc_load,
    input  wire logic [7:0]  acc_load_data,
    output logic [7:0]       status_word,
    output logic [7:0]       acc_value,
    output logic [4:0]       bank_base
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_n;
    logic rst_n;

    // two-stage release so every flop leaves reset on the same edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ----------------------------------------------------------------
    // flag arithmetic
    // ----------------------------------------------------------------
    flag_state_t st_r;
    flag_state_t st_nxt;
    bus_state_t  bus_r;
    bus_state_t  bus_nxt;
    logic [4:0]  bank_base_r;
    logic [4:0]  bank_base_nxt;

    logic        f_upd;
    logic        f_carry;
    logic        f_nibble;
    logic        f_ovf;
    logic        f_ovf_upd;
    logic        f_nibble_upd;
    logic [7:0]  f_result;

    // operand b doubles as the nibble-carry source for decimal adjust
    flag_compute u_flag_compute (
        .op         (alu_op),
        .a          (st_r.acc),
        .b          ((alu_op == OP_DA) ? {7'h00, st_r.status[`SW_BIT_NIBBLE]} : alu_b),
        .cin        (st_r.status[`SW_BIT_CARRY]),
        .upd        (f_upd),
        .carry      (f_carry),
        .nibble     (f_nibble),
        .ovf        (f_ovf),
        .ovf_upd    (f_ovf_upd),
        .nibble_upd (f_nibble_upd),
        .result     (f_result)
    );

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic        take;
    logic        wr_now;
    logic [7:0]  wbyte;
    logic [2:0]  bit_pos;

    assign take    = hsel && hready && htrans[1];
    assign wr_now  = bus_r.pend && bus_r.write;
    assign wbyte   = hwdata[7:0];
    assign bit_pos = hwdata[2:0];

    // parity of a byte
    function automatic logic odd_ones(input logic [7:0] v);
        odd_ones = ^v;
    endfunction

    // next-state of status word and accumulator
    always_comb begin
        st_nxt = st_r;
        // hardware arithmetic results first; software write below wins for
        // the same byte since it is a direct store by the program
        if (f_upd) begin
            st_nxt.acc = f_result;
            st_nxt.status[`SW_BIT_CARRY] = f_carry;                  // RQ1 RQ2
            if (f_nibble_upd)
                st_nxt.status[`SW_BIT_NIBBLE] = f_nibble;            // RQ3
            if (f_ovf_upd)
                st_nxt.status[`SW_BIT_OVF] = f_ovf;                  // RQ7
        end
        if (acc_load)
            st_nxt.acc = acc_load_data;
        if (wr_now) begin
            unique case (bus_r.addr)
                4'h0: begin
                    st_nxt.status = (wbyte & `SW_WR_MASK) | (st_nxt.status & ~`SW_WR_MASK);
                end
                4'h1: begin
                    st_nxt.acc = wbyte;
                end
                4'h2: begin
                    // single-bit write: bit 3 of data is the value, 2:0 the position
                    if (bit_pos != 3'(`SW_BIT_PARITY))
                        st_nxt.status[bit_pos] = hwdata[3];          // RQ4
                end
                4'h3: begin
                    st_nxt.status[`SW_BIT_BANK_HI:`SW_BIT_BANK_LO] = wbyte[1:0];
                end
                default: begin
                    st_nxt = st_nxt;
                end
            endcase
        end
        // parity tracks whatever the accumulator will hold
        st_nxt.status[`SW_BIT_PARITY] = odd_ones(st_nxt.acc);        // RQ5
    end

    // bank base is bank number times eight
    always_comb begin
        bank_base_nxt = {st_nxt.status[`SW_BIT_BANK_HI:`SW_BIT_BANK_LO], 3'b000};  // RQ6
    end

    // ----------------------------------------------------------------
    // bus slave: zero wait states, read data presented in data phase
    // ----------------------------------------------------------------
    always_comb begin
        bus_nxt       = bus_r;
        bus_nxt.ready = 1'b1;
        bus_nxt.pend  = take;
        if (take) begin
            bus_nxt.write = hwrite;
            bus_nxt.addr  = haddr[5:2];
            bus_nxt.rdata = 32'h0000_0000;
            if (!hwrite) begin
                unique case (haddr[5:2])
                    4'h0: bus_nxt.rdata = {24'h000000, st_r.status};
                    4'h1: bus_nxt.rdata = {24'h000000, st_r.acc};
                    4'h2: bus_nxt.rdata = {24'h000000, st_r.status};
                    4'h3: bus_nxt.rdata = {29'h00000000, bank_base_r[4:3], 1'b0} >> 1;
                    default: bus_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // state registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r        <= '{status: `SW_RESET, acc: `ACC_RESET};
            bus_r       <= '{pend: 1'b0, write: 1'b0, addr: 4'h0, ready: 1'b1, rdata: 32'h0000_0000};
            bank_base_r <= 5'h00;
        end else begin
            st_r        <= st_nxt;
            bus_r       <= bus_nxt;
            bank_base_r <= bank_base_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hreadyout   = bus_r.ready;
    assign hresp       = 1'b0;
    assign hrdata      = bus_r.rdata;
    assign status_word = st_r.status;
    assign acc_value   = st_r.acc;
    assign bank_base   = bank_base_r;
endmodule // cpu_status_flag_logic

// ### test/status_flag_checker_assertions.sv
`timescale 1ns/10ps
module status_flag_checker
    import status_word_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       nrst,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire alu_op_t    alu_op,
    input wire logic [7:0] alu_b,
    input wire logic       acc_load,
    input wire logic [7:0] status_word,
    input wire logic [7:0] acc_value,
    input wire logic [4:0] bank_base
);
    logic        wr_ph;
    logic        quiet;
    logic [8:0]  sum9;
    logic [4:0]  nib5;
    logic [15:0] prod;
    // write data phase; its store lands at the edge that ends it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            wr_ph <= 1'b0;
        else
            wr_ph <= hsel & hready & htrans[1] & hwrite;
    end
    // a store or load this cycle would override the alu result
    assign quiet = !wr_ph && !acc_load;
    assign sum9  = {1'b0, acc_value} + {1'b0, alu_b};
    assign nib5  = {1'b0, acc_value[3:0]} + {1'b0, alu_b[3:0]};
    assign prod  = {8'h00, acc_value} * {8'h00, alu_b};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ----------------------------------------------------------------
    // flag relations
    // ----------------------------------------------------------------
    a_parity_follows: assert property (status_word[0] == ^acc_value)
        else $error("parity differs from accumulator");
    a_bank_base: assert property (bank_base == {status_word[4:3], 3'b000})
        else $error("bank base not bank times eight");
    a_user_hold: assert property ($changed({status_word[5], status_word[1]}) |-> $past(wr_ph))
        else $error("user flag moved without a store");
    a_carry_set: assert property (alu_op == OP_ADD && quiet && sum9 > 9'h0FF |-> ##[1:2] status_word[7])
        else $error("carry missing after add");
    a_carry_clear: assert property (quiet && ((alu_op == OP_ADD && sum9 <= 9'h0FF) || alu_op == OP_MUL
        || alu_op == OP_DIV) |-> ##[1:2] !status_word[7])
        else $error("carry not cleared");
    a_nibble_add: assert property (alu_op == OP_ADD && quiet && nib5 > 5'h0F |-> ##[1:2] status_word[6])
        else $error("nibble carry missing");
    a_ovf_muldiv: assert property (quiet && ((alu_op == OP_MUL && prod > 16'h00FF)
        || (alu_op == OP_DIV && alu_b == 8'h00)) |-> ##[1:2] status_word[2])
        else $error("overflow missing after mul or div");
    a_ovf_add: assert property (alu_op == OP_ADD && quiet && acc_value[7] == alu_b[7]
        && sum9[7] != acc_value[7] |-> ##[1:2] status_word[2])
        else $error("overflow missing after add");
endmodule // status_flag_checker

bind cpu_status_flag_logic status_flag_checker i_chk (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .alu_op(alu_op), .alu_b(alu_b),
    .acc_load(acc_load), .status_word(status_word), .acc_value(acc_value), .bank_base(bank_base));

// ### test/core_alu_model.sv
`timescale 1ns/10ps
module core_alu_model
    import status_word_pkg::*;
(
    input  wire logic ref_clk,
    output alu_op_t    alu_op,
    output logic [7:0] alu_b,
    output logic       acc_load,
    output logic [7:0] acc_load_data
);
    // idle at time zero
    initial begin
        alu_op = OP_NONE;
        alu_b = 8'h00;
        acc_load = 1'b0;
        acc_load_data = 8'h00;
    end
    // one instruction for one edge, then idle; operand inverted so no stale value lingers
    task automatic run(input alu_op_t o, input logic [7:0] b, input int gap);
        @(posedge ref_clk);
        alu_op <= o;
        alu_b <= b;
        @(posedge ref_clk);
        alu_op <= OP_NONE;
        alu_b <= ~b;
        repeat (gap) @(posedge ref_clk);
    endtask
    // accumulator load pulse
    task automatic load(input logic [7:0] d);
        @(posedge ref_clk);
        acc_load <= 1'b1;
        acc_load_data <= d;
        @(posedge ref_clk);
        acc_load <= 1'b0;
        acc_load_data <= ~d;
    endtask
endmodule // core_alu_model

// ### test/tb_cpu_status_flag_logic.sv
`timescale 1ns/10ps
module tb_cpu_status_flag_logic
    import status_word_pkg::*;
;
    typedef struct {alu_op_t op; logic [7:0] b, e, m; logic ld; logic [7:0] v;} step_t;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp;
    logic [31:0] hrdata;
    alu_op_t     alu_op;
    logic [7:0]  alu_b, acc_load_data, status_word, acc_value;
    logic        acc_load;
    logic [4:0]  bank_base;
    int          failures = 0;
    int          checked = 0;
    int          cycles = 0;
    step_t       st[7] = '{'{OP_ADD, 8'hF9, 8'hC0, 8'hFF, 1, 8'h07}, '{OP_ADDC, 8'h01, 8'h01, 8'hFF, 0, 8'h00},
        '{OP_SUBB, 8'h03, 8'hC0, 8'hFF, 0, 8'h00}, '{OP_ADD, 8'h01, 8'h45, 8'hFF, 1, 8'h7F},
        '{OP_MUL, 8'h02, 8'h44, 8'hFE, 0, 8'h00}, '{OP_DIV, 8'h00, 8'h44, 8'hFE, 0, 8'h00},
        '{OP_DA, 8'h00, 8'hC5, 8'hFF, 1, 8'h9B}};
    cpu_status_flag_logic i_dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .alu_op(alu_op), .alu_b(alu_b), .acc_load(acc_load),
        .acc_load_data(acc_load_data), .status_word(status_word), .acc_value(acc_value), .bank_base(bank_base));
    core_alu_model i_core (.ref_clk(ref_clk), .alu_op(alu_op), .alu_b(alu_b), .acc_load(acc_load),
        .acc_load_data(acc_load_data));
    // ----------------------------------------------------------------
    // clock, timeout and verdict
    // ----------------------------------------------------------------
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one single transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic w, output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, d, 1'b1, r);
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic [7:0] m);
        logic [31:0] r;
        xfer(a, 32'h0, 1'b0, r);
        check(r & {24'h0, m}, {24'h0, e});
        // slave answers okay on every transfer
        check({31'h0, hresp}, 32'h0);
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(32'h0, 8'h00, 8'hFF);
        $display("test reset done");
        // mask drops parity where mul or div leave an accumulator we do not model
        foreach (st[i]) begin
            if (st[i].ld)
                i_core.load(st[i].v);
            i_core.run(st[i].op, st[i].b, 3);
            rd(32'h0, st[i].e, st[i].m);
        end
        // decimal adjust of 9B leaves 01 in the accumulator
        rd(32'h4, 8'h01, 8'hFF);
        check({24'h0, acc_value}, 32'h01);
        $display("test arithmetic done");
        wr(32'h4, 32'h0);
        wr(32'h0, 32'hFE);
        rd(32'h0, 8'hFE, 8'hFF);
        check({27'h0, bank_base}, 32'h18);
        wr(32'h8, 32'h05);
        rd(32'h0, 8'hDE, 8'hFF);
        i_core.run(OP_ADD, 8'h00, 3);
        rd(32'h0, 8'h1A, 8'hFF);
        wr(32'h0, 32'h01);
        rd(32'h0, 8'h00, 8'hFF);
        $display("test user flags done");
        for (int i = 0; i < 4; i++) begin
            wr(32'hC, i);
            rd(32'hC, i[7:0], 8'hFF);
            check({27'h0, bank_base}, i * 8);
        end
        wr(32'h10, 32'hFF);
        rd(32'h10, 8'h00, 8'hFF);
        rd(32'h0, 8'h18, 8'hFF);
        $display("test banks done");
        give_verdict();
    end
endmodule // tb_cpu_status_flag_logic
